// ==== pwmgc_defines.vh ====
// Function
// - Current-limit irq enable gates requests; clearing it zeroes curlim pending status.
// - Trigger irq enable gates requests; clearing it zeroes trigger pending status.
// - Independent time base takes period from phase register, else primary time base.
// - Master duty select picks shared master duty, else own duty register.
// - Dead-time mode: 00 positive, 01 negative, 10 off, 11 reserved.
// - External reset enable lets current-limit source reset independent time base.
// - Immediate update applies duty at once, else at time base period end.
// - Phase register holds bits 15..2; bits 3..2 unused as period.
// - Dead-time registers hold 12 bits in 13..2; other bits read zero.
// - Trigger divider passes one output per N+1 trigger events.
// - Trigger start value matches period wrap count before postscaler counts.
// - Ownership bits give pins to the PWM module, else to general port.
// - Polarity bits make a pin active low when set.
// - Pin pair mode: 00 complementary, 01 independent, 10 push-pull, 11 reserved.
// - Override enables drive pins from override data bits 1 and 0.
// - Active fault drives pins from fault data bits 1 and 0.
// - Active current limit drives pins from current-limit data bits 1 and 0.
// - Override sync applies overrides at period end, else next clock.
// - Source select: comparators, shared faults, independent faults 2 and 4.
// - Current-limit polarity bit makes the selected source active low.
// - Current-limit mode bit enables the current-limit function.
// - Fault mode: 00 latched, 01 cycle by cycle, 10 reserved, 11 off.
// - Fault polarity bit inverts source; fault select shares source encoding.
`ifndef PWMGC_DEFINES_VH
`define PWMGC_DEFINES_VH
`define PWMGC_A_CON 8'h00
`define PWMGC_A_DUTY 8'h04
`define PWMGC_A_PHASE 8'h08
`define PWMGC_A_DT 8'h0C
`define PWMGC_A_ALTDT 8'h10
`define PWMGC_A_TRG 8'h14
`define PWMGC_A_IO 8'h18
`define PWMGC_A_FCL 8'h1C
`define PWMGC_A_MDUTY 8'h20
`define PWMGC_CON_WMASK 16'h1FC3
`define PWMGC_PHASE_MASK 16'hFFFC
`define PWMGC_DT_MASK 16'h3FFC
`define PWMGC_TRG_MASK 16'hE03F
`define PWMGC_IO_MASK 16'hFFFD
`define PWMGC_FCL_MASK 16'h1FFF
`define PWMGC_PER_MASK 16'hFFF0
`define PWMGC_B_FLTST 15
`define PWMGC_B_CLST 14
`define PWMGC_B_TRGST 13
`define PWMGC_B_FLTIEN 12
`define PWMGC_B_CURLIM_IRQ_ENABLE 11
`define PWMGC_B_TRIGGER_IRQ_ENABLE 10
`define PWMGC_B_ITB 9
`define PWMGC_B_MASTER_DUTY_SELECT 8
`define PWMGC_B_EXTERNAL_TIMEBASE_RESET_ENABLE 1
`define PWMGC_B_IUE 0
`define PWMGC_B_HIGH_PIN_OWNERSHIP 15
`define PWMGC_B_LOW_PIN_OWNERSHIP 14
`define PWMGC_B_HIGH_PIN_INVERT 13
`define PWMGC_B_POLL 12
`define PWMGC_B_OVRH 9
`define PWMGC_B_OVRL 8
`define PWMGC_B_OVERRIDE_SYNC 0
`define PWMGC_B_CURLIM_ACTIVE_LOW 8
`define PWMGC_B_CURLIM_FUNCTION_ENABLE 7
`define PWMGC_B_FAULT_ACTIVE_LOW 2
`define PWMGC_DTC_POS 2'b00
`define PWMGC_DTC_NEG 2'b01
`define PWMGC_PM_COMP 2'b00
`define PWMGC_PM_IND 2'b01
`define PWMGC_PM_PP 2'b10
`define PWMGC_FM_LATCH 2'b00
`define PWMGC_FM_CYCLE 2'b01
`define PWMGC_ZERO16 16'h0000
`define PWMGC_ZERO12 12'h000
`endif

// ==== pwmgc_channel.v ====
`timescale 1ns/100ps
`default_nettype none
`include "pwmgc_defines.vh"
module pwmgc_channel (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] primary_period,
    input wire primary_period_start,
    input wire [3:0] comparator_in,
    input wire [3:0] shared_fault_in,
    input wire independent_fault_input_2,
    input wire independent_fault_input_4,
    input wire trigger_event,
    input wire gpio_high_data,
    input wire gpio_low_data,
    output reg high_side_output,
    output reg low_side_output,
    output reg high_pin_owned,
    output reg low_pin_owned,
    output reg trigger_out,
    output reg curlim_irq,
    output reg trigger_irq,
    output reg fault_irq
);

    // Source decode shared by current-limit and fault paths
    function src_pick;
        input [3:0] code;
        input [3:0] cmp;
        input [3:0] sflt;
        input if2;
        input if4;
        begin
            case (code)
                4'h0, 4'h1, 4'h2, 4'h3: src_pick = cmp[code[1:0]];
                4'h8, 4'h9, 4'hA, 4'hB: src_pick = sflt[code[1:0]];
                4'hD: src_pick = if2;
                4'hF: src_pick = if4;
                default: src_pick = 1'b0;
            endcase
        end
    endfunction

    reg [15:0] con_q;
    reg [15:0] duty_q;
    reg [15:0] phase_q;
    reg [15:0] dt_q;
    reg [15:0] altdt_q;
    reg [15:0] trg_q;
    reg [15:0] io_q;
    reg [15:0] fcl_q;
    reg [15:0] mduty_q;
    reg [15:0] act_duty_q;
    reg [15:0] timer_q;
    reg [5:0] roll_q;
    reg trg_started_q;
    reg [2:0] trg_cnt_q;
    reg [1:0] ovr_act_q;
    reg [1:0] ovr_en_act_q;
    reg fault_latch_q;
    reg cl_prev_q;
    reg flt_prev_q;
    reg gen_prev_q;
    reg pp_phase_q;
    reg [11:0] dt_cnt_q;
    reg [15:0] rd_d;

    wire wr_en = psel & penable & pwrite & ~pready;
    wire rd_en = psel & penable & ~pwrite & ~pready;
    wire wr_con = wr_en & (paddr == `PWMGC_A_CON);
    wire wr_trg = wr_en & (paddr == `PWMGC_A_TRG);
    wire independent_timebase_select = con_q[`PWMGC_B_ITB];
    wire [1:0] dead_time_mode = con_q[7:6];
    wire [1:0] pmode = io_q[11:10];
    wire [1:0] fmode = fcl_q[1:0];

    // Current-limit and fault conditions
    wire cl_src = src_pick(fcl_q[12:9], comparator_in, shared_fault_in,
        independent_fault_input_2, independent_fault_input_4)
        ^ fcl_q[`PWMGC_B_CURLIM_ACTIVE_LOW];
    wire cl_active = cl_src & fcl_q[`PWMGC_B_CURLIM_FUNCTION_ENABLE];
    wire flt_src = src_pick(fcl_q[6:3], comparator_in, shared_fault_in,
        independent_fault_input_2, independent_fault_input_4)
        ^ fcl_q[`PWMGC_B_FAULT_ACTIVE_LOW];
    wire flt_on = (fmode == `PWMGC_FM_LATCH) | (fmode == `PWMGC_FM_CYCLE);
    wire flt_event = flt_on & flt_src;
    wire fault_active = flt_event | fault_latch_q;

    // Time base: own period from phase, or primary with phase offset
    wire [15:0] ind_period = phase_q & `PWMGC_PER_MASK;
    wire xreset = independent_timebase_select & con_q[`PWMGC_B_EXTERNAL_TIMEBASE_RESET_ENABLE] & cl_src;
    wire ind_wrap = (timer_q >= ind_period);
    wire period_end = independent_timebase_select ? (ind_wrap | xreset) : primary_period_start;
    wire [15:0] sel_duty = con_q[`PWMGC_B_MASTER_DUTY_SELECT] ? mduty_q : duty_q;
    wire gen_raw = (timer_q <= act_duty_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_q <= `PWMGC_ZERO16;
            act_duty_q <= `PWMGC_ZERO16;
            roll_q <= 6'h00;
            pp_phase_q <= 1'b0;
        end else begin
            if (period_end) begin
                timer_q <= independent_timebase_select ? `PWMGC_ZERO16 : (phase_q & `PWMGC_PHASE_MASK);
                roll_q <= roll_q + 6'h01;
                pp_phase_q <= ~pp_phase_q;
            end else if (!independent_timebase_select && timer_q >= primary_period) begin
                timer_q <= `PWMGC_ZERO16;
            end else begin
                timer_q <= timer_q + 16'h0001;
            end
            if (con_q[`PWMGC_B_IUE] || period_end) begin
                act_duty_q <= sel_duty;
            end
        end
    end

    // Trigger start match and postscaler
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trg_started_q <= 1'b0;
            trg_cnt_q <= 3'h0;
            trigger_out <= 1'b0;
        end else begin
            trigger_out <= 1'b0;
            if (wr_trg) begin
                trg_started_q <= 1'b0;
                trg_cnt_q <= 3'h0;
            end else if (!trg_started_q) begin
                trg_started_q <= (roll_q == trg_q[5:0]);
            end else if (trigger_event) begin
                if (trg_cnt_q >= trg_q[15:13]) begin
                    trg_cnt_q <= 3'h0;
                    trigger_out <= 1'b1;
                end else begin
                    trg_cnt_q <= trg_cnt_q + 3'h1;
                end
            end
        end
    end

    // Dead-time counter restarts on every generator edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_prev_q <= 1'b0;
            dt_cnt_q <= `PWMGC_ZERO12;
        end else begin
            gen_prev_q <= gen_raw;
            if (gen_raw != gen_prev_q) begin
                dt_cnt_q <= gen_raw ? dt_q[13:2] : altdt_q[13:2];
            end else if (dt_cnt_q != `PWMGC_ZERO12) begin
                dt_cnt_q <= dt_cnt_q - 12'h001;
            end
        end
    end

    wire dt_busy = (dt_cnt_q != `PWMGC_ZERO12);
    reg gen_h;
    reg gen_l;
    always @* begin
        case (pmode)
            `PWMGC_PM_COMP: begin
                gen_h = gen_raw;
                gen_l = ~gen_raw;
            end
            `PWMGC_PM_IND: begin
                gen_h = gen_raw;
                gen_l = gen_raw;
            end
            `PWMGC_PM_PP: begin
                gen_h = gen_raw & ~pp_phase_q;
                gen_l = gen_raw & pp_phase_q;
            end
            default: begin
                gen_h = 1'b0;
                gen_l = 1'b0;
            end
        endcase
        case (dead_time_mode)
            `PWMGC_DTC_POS: begin
                gen_h = gen_h & ~dt_busy;
                gen_l = gen_l & ~dt_busy;
            end
            `PWMGC_DTC_NEG: begin
                gen_h = gen_h | (dt_busy & ~gen_raw & (pmode != `PWMGC_PM_PP));
                gen_l = gen_l | (dt_busy & gen_raw & (pmode == `PWMGC_PM_COMP));
            end
            default: begin
                gen_h = gen_h;
                gen_l = gen_l;
            end
        endcase
    end

    // Pin data selection, fault first
    wire sel_h = fault_active ? io_q[5] :
        cl_active ? io_q[3] :
        ovr_en_act_q[1] ? ovr_act_q[1] : gen_h;
    wire sel_l = fault_active ? io_q[4] :
        cl_active ? io_q[2] :
        ovr_en_act_q[0] ? ovr_act_q[0] : gen_l;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovr_act_q <= 2'b00;
            ovr_en_act_q <= 2'b00;
            fault_latch_q <= 1'b0;
            cl_prev_q <= 1'b0;
            flt_prev_q <= 1'b0;
            high_side_output <= 1'b0;
            low_side_output <= 1'b0;
            high_pin_owned <= 1'b0;
            low_pin_owned <= 1'b0;
        end else begin
            if (!io_q[`PWMGC_B_OVERRIDE_SYNC] || period_end) begin
                ovr_act_q <= io_q[7:6];
                ovr_en_act_q <= {io_q[`PWMGC_B_OVRH], io_q[`PWMGC_B_OVRL]};
            end
            if (!flt_on) begin
                fault_latch_q <= 1'b0;
            end else if (fmode == `PWMGC_FM_LATCH) begin
                fault_latch_q <= flt_src | (fault_latch_q & con_q[`PWMGC_B_FLTST]);
            end else begin
                fault_latch_q <= flt_src | (fault_latch_q & ~period_end);
            end
            cl_prev_q <= cl_active;
            flt_prev_q <= flt_event;
            high_pin_owned <= io_q[`PWMGC_B_HIGH_PIN_OWNERSHIP];
            low_pin_owned <= io_q[`PWMGC_B_LOW_PIN_OWNERSHIP];
            high_side_output <= io_q[`PWMGC_B_HIGH_PIN_OWNERSHIP] ?
                (sel_h ^ io_q[`PWMGC_B_HIGH_PIN_INVERT]) : gpio_high_data;
            low_side_output <= io_q[`PWMGC_B_LOW_PIN_OWNERSHIP] ?
                (sel_l ^ io_q[`PWMGC_B_POLL]) : gpio_low_data;
        end
    end

    // Pending status: events set, a written zero clears, enable low forces zero
    wire cl_set = cl_active & ~cl_prev_q;
    wire flt_set = flt_event & ~flt_prev_q;
    wire trg_set = trigger_out;
    wire [15:0] con_wr = pwdata[15:0];
    wire [15:0] con_wm = con_wr & `PWMGC_CON_WMASK;
    wire curlim_irq_enable_n = wr_con ? con_wr[`PWMGC_B_CURLIM_IRQ_ENABLE] : con_q[`PWMGC_B_CURLIM_IRQ_ENABLE];
    wire trigger_irq_enable_n = wr_con ? con_wr[`PWMGC_B_TRIGGER_IRQ_ENABLE] : con_q[`PWMGC_B_TRIGGER_IRQ_ENABLE];
    wire fltien_n = wr_con ? con_wr[`PWMGC_B_FLTIEN] : con_q[`PWMGC_B_FLTIEN];
    wire cl_keep = con_q[`PWMGC_B_CLST] & ~(wr_con & ~con_wr[`PWMGC_B_CLST]);
    wire trg_keep = con_q[`PWMGC_B_TRGST] & ~(wr_con & ~con_wr[`PWMGC_B_TRGST]);
    wire flt_keep = con_q[`PWMGC_B_FLTST] & ~(wr_con & ~con_wr[`PWMGC_B_FLTST]);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con_q <= `PWMGC_ZERO16;
            duty_q <= `PWMGC_ZERO16;
            phase_q <= `PWMGC_ZERO16;
            dt_q <= `PWMGC_ZERO16;
            altdt_q <= `PWMGC_ZERO16;
            trg_q <= `PWMGC_ZERO16;
            io_q <= `PWMGC_ZERO16;
            fcl_q <= `PWMGC_ZERO16;
            mduty_q <= `PWMGC_ZERO16;
            curlim_irq <= 1'b0;
            trigger_irq <= 1'b0;
            fault_irq <= 1'b0;
        end else begin
            if (wr_con) begin
                con_q[12:0] <= con_wm[12:0];
            end
            con_q[`PWMGC_B_CLST] <= curlim_irq_enable_n & (cl_set | cl_keep);
            con_q[`PWMGC_B_TRGST] <= trigger_irq_enable_n & (trg_set | trg_keep);
            con_q[`PWMGC_B_FLTST] <= fltien_n & (flt_set | flt_keep);
            curlim_irq <= curlim_irq_enable_n & cl_set;
            trigger_irq <= trigger_irq_enable_n & trg_set;
            fault_irq <= fltien_n & flt_set;
            if (wr_en) begin
                case (paddr)
                    `PWMGC_A_DUTY: duty_q <= pwdata[15:0];
                    `PWMGC_A_PHASE: phase_q <= pwdata[15:0] & `PWMGC_PHASE_MASK;
                    `PWMGC_A_DT: dt_q <= pwdata[15:0] & `PWMGC_DT_MASK;
                    `PWMGC_A_ALTDT: altdt_q <= pwdata[15:0] & `PWMGC_DT_MASK;
                    `PWMGC_A_TRG: trg_q <= pwdata[15:0] & `PWMGC_TRG_MASK;
                    `PWMGC_A_IO: io_q <= pwdata[15:0] & `PWMGC_IO_MASK;
                    `PWMGC_A_FCL: fcl_q <= pwdata[15:0] & `PWMGC_FCL_MASK;
                    `PWMGC_A_MDUTY: mduty_q <= pwdata[15:0];
                    default: mduty_q <= mduty_q;
                endcase
            end
        end
    end

    // APB: one wait cycle; read data and ready leave flip-flops together
    reg map_hit;
    always @* begin
        map_hit = 1'b1;
        case (paddr)
            `PWMGC_A_CON: rd_d = con_q;
            `PWMGC_A_DUTY: rd_d = duty_q;
            `PWMGC_A_PHASE: rd_d = phase_q;
            `PWMGC_A_DT: rd_d = dt_q;
            `PWMGC_A_ALTDT: rd_d = altdt_q;
            `PWMGC_A_TRG: rd_d = trg_q;
            `PWMGC_A_IO: rd_d = io_q;
            `PWMGC_A_FCL: rd_d = fcl_q;
            `PWMGC_A_MDUTY: rd_d = mduty_q;
            default: begin
                rd_d = `PWMGC_ZERO16;
                map_hit = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~map_hit;
            if (rd_en) begin
                prdata <= {16'h0000, rd_d};
            end
        end
    end

endmodule // pwmgc_channel
`default_nettype wire

// ==== pwmgc_channel_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "pwmgc_defines.vh"
module pwmgc_channel_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic gpio_high_data,
    input wire logic high_side_output,
    input wire logic high_pin_owned,
    input wire logic low_pin_owned,
    input wire logic trigger_event,
    input wire logic trigger_out,
    input wire logic curlim_irq,
    input wire logic trigger_irq
);
    logic [1:0] own_q;
    wire acc = psel && penable && !pready;
    wire rd_done = psel && penable && pready && !pwrite;
    wire io_wr = psel && penable && pready && pwrite && paddr == `PWMGC_A_IO;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Ownership bits as last written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) own_q <= 2'h0;
        else if (io_wr) own_q <= pwdata[15:14];
    end
    property p_wait; acc |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("pready not after one wait state");
    property p_rdy_pulse; pready |=> !pready; endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready longer than one cycle");
    property p_unmapped; acc && paddr > `PWMGC_A_MDUTY |=> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
    property p_err_rdy; pslverr |-> pready; endproperty
    a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
    property p_upper; rd_done |-> prdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read data not zero");
    property p_dt_rd;
        rd_done && (paddr == `PWMGC_A_DT || paddr == `PWMGC_A_ALTDT)
            |-> (prdata[15:0] & ~`PWMGC_DT_MASK) == 16'h0000;
    endproperty
    a_dt_rd: assert property (p_dt_rd) else $error("dead time spare bits set");
    property p_ph_rd; rd_done && paddr == `PWMGC_A_PHASE |-> prdata[1:0] == 2'h0; endproperty
    a_ph_rd: assert property (p_ph_rd) else $error("phase low bits set");
    property p_own;
        own_q == $past(own_q) && own_q == $past(own_q, 2)
            |-> {high_pin_owned, low_pin_owned} == own_q;
    endproperty
    a_own: assert property (p_own) else $error("pin ownership differs");
    property p_gpio;
        !high_pin_owned && !$past(high_pin_owned) && $past(presetn)
            |-> high_side_output == $past(gpio_high_data);
    endproperty
    a_gpio: assert property (p_gpio) else $error("unowned pin not port data");
    property p_trg_cause; trigger_out |-> $past(trigger_event); endproperty
    a_trg_cause: assert property (p_trg_cause) else $error("trigger without event");
    property p_trg_irq; trigger_irq |-> $past(trigger_out); endproperty
    a_trg_irq: assert property (p_trg_irq) else $error("trigger irq without trigger");
    property p_cl_irq; curlim_irq |=> !curlim_irq; endproperty
    a_cl_irq: assert property (p_cl_irq) else $error("curlim irq not a pulse");
    c_io_wr: cover property (io_wr);
    c_trg: cover property (trigger_out);
    c_err: cover property (pslverr);
endmodule // pwmgc_channel_sva
bind pwmgc_channel pwmgc_channel_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .gpio_high_data(gpio_high_data),
    .high_side_output(high_side_output), .high_pin_owned(high_pin_owned),
    .low_pin_owned(low_pin_owned), .trigger_event(trigger_event),
    .trigger_out(trigger_out), .curlim_irq(curlim_irq), .trigger_irq(trigger_irq));
`default_nettype wire

// ==== pwmgc_stage_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pwmgc_stage_model #(parameter int PER = 40) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trig_on,
    input wire logic [9:0] src,
    output logic [15:0] primary_period,
    output logic primary_period_start,
    output logic [3:0] comparator_in,
    output logic [3:0] shared_fault_in,
    output logic independent_fault_input_2,
    output logic independent_fault_input_4,
    output logic trigger_event
);
    logic [7:0] cnt_q;
    assign primary_period = 16'(PER);
    // Primary time base, trigger compare and settled comparator levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 8'h00;
            primary_period_start <= 1'b0;
            trigger_event <= 1'b0;
            {independent_fault_input_4, independent_fault_input_2} <= 2'h0;
            {shared_fault_in, comparator_in} <= 8'h00;
        end else begin
            cnt_q <= (cnt_q == 8'(PER)) ? 8'h00 : cnt_q + 8'h01;
            primary_period_start <= cnt_q == 8'(PER);
            trigger_event <= trig_on && cnt_q[1:0] == 2'h3;
            {independent_fault_input_4, independent_fault_input_2} <= src[9:8];
            {shared_fault_in, comparator_in} <= src[7:0];
        end
    end
endmodule // pwmgc_stage_model
`default_nettype wire

// ==== tb_pwm_generator_channel_control.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_pwm_generator_channel_control;
    logic pclk, presetn, psel, penable, pwrite, trig_on, gpio_h, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, rq;
    logic [9:0] src;
    wire [31:0] prdata;
    wire [15:0] per;
    wire [3:0] cmp, sflt;
    wire pready, pslverr, h_out, l_out, own_h, own_l, t_out, cl_irq, t_irq, per_st, if2, if4, t_ev;
    wire f_irq;
    int fl_seen = 0;
    int error_cnt = 0, n_tests = 0, cl_seen = 0, tg_seen = 0, ev_cnt = 0, hi, bad, i, n;
    int outs[$];
    logic [7:0] adr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [15:0] exv [9] = '{16'h1FC3, 16'hFFEF, 16'hFFFC, 16'h3FFC, 16'h3FFC, 16'hE03F,
        16'hFFFD, 16'h1FFF, 16'hFFEF};
    logic [3:0] cd [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hF};
    pwmgc_channel dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .primary_period(per), .primary_period_start(per_st),
        .comparator_in(cmp), .shared_fault_in(sflt), .independent_fault_input_2(if2),
        .independent_fault_input_4(if4), .trigger_event(t_ev), .gpio_high_data(gpio_h),
        .gpio_low_data(gpio_h), .high_side_output(h_out), .low_side_output(l_out),
        .high_pin_owned(own_h), .low_pin_owned(own_l), .trigger_out(t_out),
        .curlim_irq(cl_irq), .trigger_irq(t_irq), .fault_irq(f_irq));
    pwmgc_stage_model #(.PER(40)) part_u (.pclk(pclk), .presetn(presetn), .trig_on(trig_on),
        .src(src), .primary_period(per), .primary_period_start(per_st), .comparator_in(cmp),
        .shared_fault_in(sflt), .independent_fault_input_2(if2),
        .independent_fault_input_4(if4), .trigger_event(t_ev));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        gpio_h <= ~gpio_h;
        if (t_ev === 1'b1) ev_cnt++;
        if (t_out === 1'b1) outs.push_back(ev_cnt);
        if (cl_irq === 1'b1) cl_seen++;
        if (t_irq === 1'b1) tg_seen++;
        if (f_irq === 1'b1) fl_seen++;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rq = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic pins(input logic [1:0] e);
        int k;
        k = 0;
        while ({h_out, l_out} !== e && k < 300) begin
            @(posedge pclk);
            k++;
        end
        chk({30'h0, h_out, l_out}, {30'h0, e});
    endtask
    task automatic gen;
        hi = 0;
        bad = 0;
        repeat (50) @(posedge pclk);
        repeat (100) begin
            @(posedge pclk);
            hi += (h_out === 1'b1);
            bad += (l_out !== !h_out);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        close_out();
    end
    initial begin
        {psel, penable, pwrite, trig_on, gpio_h} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        src = 10'h000;
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 9; i++) begin
            apb(1'b0, adr[i], 32'h0);
            chk(rq, 32'h0);
        end
        for (i = 0; i < 9; i++) begin
            apb(1'b1, adr[i], {16'hFFFF, (i == 1 || i == 8) ? 16'hFFEF : 16'hFFFF});
            apb(1'b0, adr[i], 32'h0);
            chk(rq, {16'h0, exv[i]});
        end
        for (i = 0; i < 9; i++) apb(1'b1, adr[i], (i == 1 || i == 8) ? 32'h8 : 32'h0);
        apb(1'b1, 8'h24, 32'hFFFF);
        chk(rerr, 1'b1);
        apb(1'b0, 8'h24, 32'h0);
        chk({rerr, rq}, {1'b1, 32'h0});
        apb(1'b1, 8'h18, 32'hC3B4);
        pins(2'b10);
        apb(1'b1, 8'h18, 32'hF3B4);
        pins(2'b01);
        apb(1'b1, 8'h18, 32'hC3B4);
        pins(2'b10);
        for (i = 0; i < 10; i++) begin
            apb(1'b1, 8'h1C, {19'h0, cd[i], 9'h083});
            src <= 10'h001 << i;
            pins(2'b01);
            src <= 10'h000;
            pins(2'b10);
        end
        apb(1'b1, 8'h1C, 32'h0183);
        pins(2'b01);
        src <= 10'h001;
        pins(2'b10);
        apb(1'b1, 8'h1C, 32'h0883);
        src <= 10'h3FF;
        repeat (50) @(posedge pclk);
        chk({h_out, l_out}, 2'b10);
        src <= 10'h000;
        apb(1'b1, 8'h1C, 32'h0281);
        apb(1'b1, 8'h00, 32'h1000);
        src <= 10'h002;
        pins(2'b01);
        src <= 10'h003;
        pins(2'b11);
        repeat (2) @(posedge pclk);
        chk(fl_seen, 1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rq, 32'h9000);
        src <= 10'h000;
        pins(2'b10);
        apb(1'b1, 8'h1C, 32'h0283);
        cl_seen = 0;
        apb(1'b1, 8'h00, 32'h0800);
        src <= 10'h002;
        pins(2'b01);
        repeat (5) @(posedge pclk);
        chk(cl_seen, 1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rq, 32'h4800);
        apb(1'b1, 8'h00, 32'h0800);
        apb(1'b0, 8'h00, 32'h0);
        chk(rq, 32'h0800);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rq, 32'h0);
        src <= 10'h000;
        pins(2'b10);
        src <= 10'h002;
        pins(2'b01);
        chk(cl_seen, 1);
        src <= 10'h000;
        apb(1'b1, 8'h1C, 32'h0003);
        tg_seen = 0;
        apb(1'b1, 8'h00, 32'h0400);
        for (i = 0; i < 8; i += 3) begin
            apb(1'b1, 8'h14, {16'h0, 3'(i), 13'h0000});
            outs.delete();
            trig_on <= 1'b1;
            n = 0;
            while (outs.size() < 3 && n < 4000) begin
                @(posedge pclk);
                n++;
            end
            trig_on <= 1'b0;
            repeat (5) @(posedge pclk);
            chk(32'(outs[2] - outs[1]), 32'(i + 1));
        end
        chk(tg_seen >= 3, 1'b1);
        apb(1'b0, 8'h00, 32'h0);
        chk(rq, 32'h2400);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rq, 32'h0);
        apb(1'b1, 8'h18, 32'hC000);
        apb(1'b1, 8'h04, 32'h0008);
        apb(1'b1, 8'h20, 32'h0030);
        apb(1'b1, 8'h00, 32'h0181);
        gen();
        chk({hi, bad}, {32'd100, 32'd0});
        apb(1'b1, 8'h00, 32'h0081);
        gen();
        chk({hi > 0 && hi < 100, bad}, {1'b1, 32'd0});
        apb(1'b1, 8'h18, 32'hC400);
        gen();
        chk({hi > 0 && hi < 100, bad}, {1'b1, 32'd100});
        close_out();
    end
endmodule // tb_pwm_generator_channel_control
`default_nettype wire
